//--- verilog/stt_cfg.svh
// offsets, field positions, reset values and counts of the slot transfer
`ifndef STT_CFG_SVH
`define STT_CFG_SVH

// ****************************************
// register offsets on the processor port
// ****************************************
`define STT_OFF_MEM_ADDR 4'h1
`define STT_OFF_MEM_DATA 4'h2
`define STT_OFF_DATA_A   4'h3
`define STT_OFF_DATA_B   4'h4
`define STT_OFF_RX_A     4'h5
`define STT_OFF_RX_B     4'h6
`define STT_OFF_TX_A     4'h7
`define STT_OFF_TX_B     4'h8
`define STT_OFF_CTRL     4'h9

// ****************************************
// field positions
// ****************************************
`define STT_SEL_BIT   7
`define STT_EN_A_BIT  6
`define STT_EN_B_BIT  7
`define STT_CT_A_LSB  0
`define STT_CT_B_LSB  3
`define STT_CT_W      3

// ****************************************
// reset values and counts
// ****************************************
`define STT_REG_RST   8'h00
`define STT_CNT_W     10
`define STT_LAST_BIT  3'h7

`endif

//--- verilog/stt_pkg.sv
// types of the synchronous slot transfer block
package stt_pkg;

  `include "stt_cfg.svh"

  typedef enum logic {
    STT_IF_PCM = 1'b0,
    STT_IF_SUB = 1'b1
  } stt_if_t;

  // one synchroniser stage for every pin that enters the block except clock and reset
  typedef struct packed {
    logic       cs_n;
    logic       wr_n;
    logic       rd_n;
    logic       fs;
    logic       bclk;
    logic       pcm_rx;
    logic       sub_rx;
    logic [3:0] addr;
    logic [7:0] data;
    logic [1:0] sub_mode;
    logic [1:0] pcm_mode;
  } stt_pins_t;

  typedef struct packed {
    stt_pins_t             p1;
    stt_pins_t             p2;
    logic                  wr_prev;
    logic                  bclk_prev;
    logic [7:0]            mem_addr;
    logic [7:0]            mem_data;
    logic [7:0]            data_a;
    logic [7:0]            data_b;
    logic [7:0]            rx_addr_a;
    logic [7:0]            rx_addr_b;
    logic [7:0]            tx_addr_a;
    logic [7:0]            tx_addr_b;
    logic [7:0]            xfer_ctrl;
    logic [`STT_CNT_W-1:0] bit_cnt;
    logic [7:0]            rd_data;
    logic                  rd_oe_n;
    logic                  pcm_tx;
    logic                  pcm_oe_n;
    logic                  sub_tx;
    logic                  sub_oe_n;
  } stt_state_t;

endpackage

//--- verilog/stt_xfer.sv
// two-channel synchronous time-slot transfer with its register port
//
// What this block does
// - sub modes 0,1 need bits 2..1 or bit 1 zero; mode 2 uses all
// - sub mode 3 uses bits 6..3 and 0; bits 3..1 are 000 or 100
// - eight-bit memory access address register, readable and writable; no logic uses its bits
// - eight-bit memory access data register, readable and writable
// - channel A buffer holds the byte moved on channel A
// - channel A buffer bit 7 is first on the line, bit 0 last
// - channel B buffer holds the byte moved on channel B
// - channel B buffer bit 7 is first on the line, bit 0 last
// - channel A receive bit 7: 0 highway, 1 subscriber side
// - channel A receive bits 6..0 pick port and slot, shared encoding
// - byte caught from channel A receive slot is readable in buffer A
// - channel B receive bit 7: 0 highway, 1 subscriber side
// - channel B receive bits 6..0 pick slot; byte readable in buffer B
// - channel A transmit bit 7: 0 highway, 1 subscriber side
// - buffer A goes out in the slot given by transmit address A
// - channel B transmit bit 7: 0 highway, 1 subscriber side
// - buffer B goes out in the slot given by transmit address B
// - a channel moves data only while its enable bit is 1
`timescale 1ns/10ps

module stt_xfer (
  input  wire logic       clock_i,
  input  wire logic       reset_i,
  input  wire logic       cs_n_i,
  input  wire logic       wr_n_i,
  input  wire logic       rd_n_i,
  input  wire logic [3:0] addr_i,
  input  wire logic [7:0] data_i,
  output      logic [7:0] data_o,
  output      logic       data_oe_n_o,
  input  wire logic [1:0] sub_mode_i,
  input  wire logic [1:0] pcm_mode_i,
  input  wire logic       frame_sync_i,
  input  wire logic       bit_clock_i,
  input  wire logic       pcm_rx_i,
  output      logic       pcm_tx_o,
  output      logic       pcm_oe_n_o,
  input  wire logic       sub_rx_i,
  output      logic       sub_tx_o,
  output      logic       sub_oe_n_o
);

  `include "stt_cfg.svh"

  // ****************************************
  // slot decoding
  // ****************************************

  // returns {valid, flat slot}; a must-be-zero bit that is set makes
  // the address invalid, so a bad setting never touches any slot
  function automatic logic [7:0] slot_decode(
    input logic [7:0] a,
    input logic [1:0] sm,
    input logic [1:0] pm
  );
    logic [7:0] r;
    r = 8'h00;
    if (a[`STT_SEL_BIT] == stt_pkg::STT_IF_SUB) begin
      case (sm)
        2'h0:    r = {~|a[2:1], 2'h0, a[6:3], a[0]};
        2'h1:    r = {~a[1], 1'b0, a[6:2], a[0]};
        2'h2:    r = {1'b1, a[6:0]};
        default: r = {(a[2:1] == 2'h0), 2'h0, a[3], a[6:4], a[0]};
      endcase
    end else begin
      case (pm)
        2'h0:    r = {~|a[2:1], 2'h0, a[6:3], a[0]};
        2'h1:    r = {~a[2], 1'b0, a[6:3], a[1:0]};
        default: r = {1'b1, a[6:0]};
      endcase
    end
    return r;
  endfunction

  // bits of the slot that a channel type moves
  function automatic logic [7:0] type_mask(input logic [2:0] ct);
    logic [7:0] m;
    m = 8'h00;
    case (ct)
      3'h1:    m = 8'hFF;
      3'h2:    m = 8'h0F;
      3'h3:    m = 8'hF0;
      3'h4:    m = 8'h03;
      3'h5:    m = 8'h0C;
      3'h6:    m = 8'h30;
      3'h7:    m = 8'hC0;
      default: m = 8'h00;
    endcase
    return m;
  endfunction

  // one bit position of the frame belongs to the channel
  function automatic logic slot_hit(
    input logic                  en,
    input logic [7:0]            a,
    input logic [`STT_CNT_W-1:0] cnt,
    input logic [1:0]            sm,
    input logic [1:0]            pm,
    input logic [2:0]            ct
  );
    logic [7:0] dec;
    logic [7:0] msk;
    dec = slot_decode(a, sm, pm);
    msk = type_mask(ct);
    return en && dec[7] && (dec[6:0] == cnt[`STT_CNT_W-1:3]) &&
           msk[`STT_LAST_BIT - cnt[2:0]];
  endfunction

  // ****************************************
  // state and derived terms
  // ****************************************
  stt_pkg::stt_state_t q;
  stt_pkg::stt_state_t d;
  stt_pkg::stt_pins_t  pins;

  logic                  wr_act;
  logic                  rd_act;
  logic                  cpu_wr;
  logic                  rise_ev;
  logic                  fall_ev;
  logic                  en_a;
  logic                  en_b;
  logic [2:0]            ct_a;
  logic [2:0]            ct_b;
  logic [`STT_CNT_W-1:0] cnt_n;
  logic [2:0]            rx_idx;
  logic [2:0]            tx_idx;
  logic                  rx_hit_a;
  logic                  rx_hit_b;
  logic                  tx_hit_a;
  logic                  tx_hit_b;
  logic                  rx_val_a;
  logic                  rx_val_b;

  assign pins = '{cs_n: cs_n_i, wr_n: wr_n_i, rd_n: rd_n_i,
                  fs: frame_sync_i, bclk: bit_clock_i,
                  pcm_rx: pcm_rx_i, sub_rx: sub_rx_i, addr: addr_i,
                  data: data_i, sub_mode: sub_mode_i,
                  pcm_mode: pcm_mode_i};

  assign wr_act  = !q.p2.cs_n && !q.p2.wr_n;
  assign rd_act  = !q.p2.cs_n && !q.p2.rd_n;
  assign cpu_wr  = wr_act && !q.wr_prev;
  assign rise_ev = q.p2.bclk && !q.bclk_prev;
  assign fall_ev = !q.p2.bclk && q.bclk_prev;
  assign en_a    = q.xfer_ctrl[`STT_EN_A_BIT];
  assign en_b    = q.xfer_ctrl[`STT_EN_B_BIT];
  assign ct_a    = q.xfer_ctrl[`STT_CT_A_LSB +: `STT_CT_W];
  assign ct_b    = q.xfer_ctrl[`STT_CT_B_LSB +: `STT_CT_W];
  // frame sync restarts the bit count so every slot recurs per frame
  assign cnt_n   = q.p2.fs ? '0 : q.bit_cnt + `STT_CNT_W'(1);
  assign rx_idx  = `STT_LAST_BIT - q.bit_cnt[2:0];
  assign tx_idx  = `STT_LAST_BIT - cnt_n[2:0];

  assign rx_hit_a = slot_hit(en_a, q.rx_addr_a, q.bit_cnt,
                             q.p2.sub_mode, q.p2.pcm_mode, ct_a);
  assign rx_hit_b = slot_hit(en_b, q.rx_addr_b, q.bit_cnt,
                             q.p2.sub_mode, q.p2.pcm_mode, ct_b);
  assign tx_hit_a = slot_hit(en_a, q.tx_addr_a, cnt_n,
                             q.p2.sub_mode, q.p2.pcm_mode, ct_a);
  assign tx_hit_b = slot_hit(en_b, q.tx_addr_b, cnt_n,
                             q.p2.sub_mode, q.p2.pcm_mode, ct_b);
  assign rx_val_a = q.rx_addr_a[`STT_SEL_BIT] ? q.p2.sub_rx
                                              : q.p2.pcm_rx;
  assign rx_val_b = q.rx_addr_b[`STT_SEL_BIT] ? q.p2.sub_rx
                                              : q.p2.pcm_rx;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    d           = q;
    d.p1        = pins;
    d.p2        = q.p1;
    d.wr_prev   = wr_act;
    d.bclk_prev = q.p2.bclk;

    // capture on the falling bit clock, when the line is settled
    if (fall_ev) begin
      if (rx_hit_a) begin
        d.data_a[rx_idx] = rx_val_a;
      end
      if (rx_hit_b) begin
        d.data_b[rx_idx] = rx_val_b;
      end
    end

    // drive on the rising bit clock; channel A wins a shared slot
    if (rise_ev) begin
      d.bit_cnt  = cnt_n;
      d.pcm_oe_n = 1'b1;
      d.sub_oe_n = 1'b1;
      if (tx_hit_b) begin
        if (q.tx_addr_b[`STT_SEL_BIT]) begin
          d.sub_tx   = q.data_b[tx_idx];
          d.sub_oe_n = 1'b0;
        end else begin
          d.pcm_tx   = q.data_b[tx_idx];
          d.pcm_oe_n = 1'b0;
        end
      end
      if (tx_hit_a) begin
        if (q.tx_addr_a[`STT_SEL_BIT]) begin
          d.sub_tx   = q.data_a[tx_idx];
          d.sub_oe_n = 1'b0;
        end else begin
          d.pcm_tx   = q.data_a[tx_idx];
          d.pcm_oe_n = 1'b0;
        end
      end
    end

    // a processor write lands after the serial capture, so it wins
    if (cpu_wr) begin
      case (q.p2.addr)
        `STT_OFF_MEM_ADDR: d.mem_addr  = q.p2.data;
        `STT_OFF_MEM_DATA: d.mem_data  = q.p2.data;
        `STT_OFF_DATA_A:   d.data_a    = q.p2.data;
        `STT_OFF_DATA_B:   d.data_b    = q.p2.data;
        `STT_OFF_RX_A:     d.rx_addr_a = q.p2.data;
        `STT_OFF_RX_B:     d.rx_addr_b = q.p2.data;
        `STT_OFF_TX_A:     d.tx_addr_a = q.p2.data;
        `STT_OFF_TX_B:     d.tx_addr_b = q.p2.data;
        `STT_OFF_CTRL:     d.xfer_ctrl = q.p2.data;
        default:           d.xfer_ctrl = q.xfer_ctrl;
      endcase
    end

    // read data follows the strobe; unmapped offsets read as zero
    d.rd_oe_n = !rd_act;
    if (rd_act) begin
      case (q.p2.addr)
        `STT_OFF_MEM_ADDR: d.rd_data = q.mem_addr;
        `STT_OFF_MEM_DATA: d.rd_data = q.mem_data;
        `STT_OFF_DATA_A:   d.rd_data = q.data_a;
        `STT_OFF_DATA_B:   d.rd_data = q.data_b;
        `STT_OFF_RX_A:     d.rd_data = q.rx_addr_a;
        `STT_OFF_RX_B:     d.rd_data = q.rx_addr_b;
        `STT_OFF_TX_A:     d.rd_data = q.tx_addr_a;
        `STT_OFF_TX_B:     d.rd_data = q.tx_addr_b;
        `STT_OFF_CTRL:     d.rd_data = q.xfer_ctrl;
        default:           d.rd_data = `STT_REG_RST;
      endcase
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      q           <= '0;
      q.p1.cs_n   <= 1'b1;
      q.p1.wr_n   <= 1'b1;
      q.p1.rd_n   <= 1'b1;
      q.p2.cs_n   <= 1'b1;
      q.p2.wr_n   <= 1'b1;
      q.p2.rd_n   <= 1'b1;
      q.xfer_ctrl <= `STT_REG_RST;
      q.rd_oe_n   <= 1'b1;
      q.pcm_oe_n  <= 1'b1;
      q.sub_oe_n  <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign data_o      = q.rd_data;
  assign data_oe_n_o = q.rd_oe_n;
  assign pcm_tx_o    = q.pcm_tx;
  assign pcm_oe_n_o  = q.pcm_oe_n;
  assign sub_tx_o    = q.sub_tx;
  assign sub_oe_n_o  = q.sub_oe_n;

  // ****************************************
  // checks
  // ****************************************
  chk_idle_hold_a: assert property (@(posedge clock_i) disable iff (reset_i)
    (fall_ev && !en_a && !cpu_wr) |=> $stable(q.data_a))
    else $error("channel A buffer changed while disabled");

  chk_rx_catch_a: assert property (@(posedge clock_i) disable iff (reset_i)
    (fall_ev && rx_hit_a && !cpu_wr)
    |=> q.data_a[$past(rx_idx)] == $past(rx_val_a))
    else $error("channel A receive bit not captured");

  chk_rx_catch_b: assert property (@(posedge clock_i) disable iff (reset_i)
    (fall_ev && rx_hit_b && !cpu_wr)
    |=> q.data_b[$past(rx_idx)] == $past(rx_val_b))
    else $error("channel B receive bit not captured");

  chk_tx_pcm_a: assert property (@(posedge clock_i) disable iff (reset_i)
    (rise_ev && tx_hit_a && !q.tx_addr_a[`STT_SEL_BIT])
    |=> !pcm_oe_n_o && pcm_tx_o == $past(q.data_a[tx_idx]))
    else $error("channel A bit not sent on highway");

  chk_tx_sub_a: assert property (@(posedge clock_i) disable iff (reset_i)
    (rise_ev && tx_hit_a && q.tx_addr_a[`STT_SEL_BIT])
    |=> !sub_oe_n_o && sub_tx_o == $past(q.data_a[tx_idx]))
    else $error("channel A bit not sent on subscriber side");

  chk_tx_pcm_b: assert property (@(posedge clock_i) disable iff (reset_i)
    (rise_ev && tx_hit_b && !q.tx_addr_b[`STT_SEL_BIT] &&
     !(tx_hit_a && !q.tx_addr_a[`STT_SEL_BIT]))
    |=> !pcm_oe_n_o && pcm_tx_o == $past(q.data_b[tx_idx]))
    else $error("channel B bit not sent on highway");

  chk_tx_sub_b: assert property (@(posedge clock_i) disable iff (reset_i)
    (rise_ev && tx_hit_b && q.tx_addr_b[`STT_SEL_BIT] &&
     !(tx_hit_a && q.tx_addr_a[`STT_SEL_BIT]))
    |=> !sub_oe_n_o && sub_tx_o == $past(q.data_b[tx_idx]))
    else $error("channel B bit not sent on subscriber side");

  chk_tx_release: assert property (@(posedge clock_i) disable iff (reset_i)
    (rise_ev && !en_a && !en_b) |=> pcm_oe_n_o && sub_oe_n_o)
    else $error("line driven with both channels disabled");

  chk_frame_start: assert property (@(posedge clock_i) disable iff (reset_i)
    (rise_ev && q.p2.fs) |=> q.bit_cnt == '0)
    else $error("bit count not restarted by frame sync");

  chk_mem_write: assert property (@(posedge clock_i) disable iff (reset_i)
    (cpu_wr && q.p2.addr == `STT_OFF_MEM_DATA)
    |=> q.mem_data == $past(q.p2.data))
    else $error("memory access data not written");

  chk_mode3_port: assert property (@(posedge clock_i) disable iff (reset_i)
    (q.rx_addr_b[`STT_SEL_BIT] && q.p2.sub_mode == 2'h3 &&
     q.rx_addr_b[2:1] != 2'h0) |-> !rx_hit_b)
    else $error("unsupported mode 3 port address was used");

  chk_mode0_zero: assert property (@(posedge clock_i) disable iff (reset_i)
    (q.rx_addr_b[`STT_SEL_BIT] && q.p2.sub_mode == 2'h0 &&
     q.rx_addr_b[2:1] != 2'h0) |-> !rx_hit_b)
    else $error("mode 0 address with must-be-zero bits set was used");

  chk_read_back: assert property (@(posedge clock_i) disable iff (reset_i)
    (rd_act && q.p2.addr == `STT_OFF_RX_A)
    |=> !data_oe_n_o && data_o == $past(q.rx_addr_a))
    else $error("receive address A read back wrong");

endmodule

//--- sim/stt_far_end.sv
// far-side model: bit clock, frame sync, receive lines and line capture
`timescale 1ns/10ps

module stt_far_end (
  input  wire logic clock_i,
  input  wire logic reset_i,
  input  wire logic pcm_tx_i,
  input  wire logic pcm_oe_n_i,
  input  wire logic sub_tx_i,
  input  wire logic sub_oe_n_i,
  output      logic bit_clock_o,
  output      logic frame_sync_o,
  output      logic pcm_rx_o,
  output      logic sub_rx_o
);
  // ****************************************
  // short frame of 8 slots keeps the run brief
  // ****************************************
  logic [3:0] div_q;
  logic [5:0] cnt_q;
  logic [5:0] nxt;
  logic [7:0] cap_pcm [0:7];
  logic [7:0] cap_sub [0:7];

  function automatic logic [7:0] rx_byte(input logic       line,
                                         input logic [2:0] slot);
    return {line, slot, 4'hA ^ {1'b0, slot}};
  endfunction

  function automatic logic rx_bit(input logic line, input logic [5:0] n);
    logic [7:0] b;
    b = rx_byte(line, n[5:3]);
    return b[3'h7 - n[2:0]];
  endfunction

  assign nxt = cnt_q + 6'h01;

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      div_q        <= 4'h0;
      cnt_q        <= 6'h3F;
      bit_clock_o  <= 1'b0;
      frame_sync_o <= 1'b0;
      pcm_rx_o     <= 1'b0;
      sub_rx_o     <= 1'b0;
    end else begin
      div_q <= (div_q == 4'h4) ? 4'h0 : div_q + 4'h1;
      if (div_q == 4'h4) begin
        bit_clock_o <= ~bit_clock_o;
        if (!bit_clock_o) begin
          // frames follow each other without a gap
          cnt_q    <= nxt;
          pcm_rx_o <= rx_bit(1'b0, nxt);
          sub_rx_o <= rx_bit(1'b1, nxt);
        end else begin
          frame_sync_o <= (cnt_q == 6'h3F);
          // first bit of a slot ends up in bit 7 after eight shifts
          if (!pcm_oe_n_i) begin
            cap_pcm[cnt_q[5:3]] <= {cap_pcm[cnt_q[5:3]][6:0], pcm_tx_i};
          end
          if (!sub_oe_n_i) begin
            cap_sub[cnt_q[5:3]] <= {cap_sub[cnt_q[5:3]][6:0], sub_tx_i};
          end
        end
      end
    end
  end
endmodule

//--- sim/stt_xfer_bench.sv
// self-checking bench of the slot transfer block and its register port
`timescale 1ns/10ps
`include "stt_cfg.svh"

`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin \
  mismatches++; $display("ERROR t=%0t got=%h exp=%h", $time, got, exp); \
  end end

module stt_xfer_bench;
  logic       clock_i;
  logic       reset_i;
  logic       cs_n;
  logic       wr_n;
  logic       rd_n;
  logic [3:0] addr;
  logic [7:0] data;
  logic [7:0] data_o;
  logic       data_oe_n_o;
  logic [1:0] sub_mode;
  logic [1:0] pcm_mode;
  logic       fs;
  logic       bclk;
  logic       pcm_rx;
  logic       pcm_tx;
  logic       pcm_oe_n;
  logic       sub_rx;
  logic       sub_tx;
  logic       sub_oe_n;
  logic [7:0] e;
  int         mismatches;
  int         num_checks;

  stt_xfer i_stt_xfer (.clock_i(clock_i), .reset_i(reset_i), .cs_n_i(cs_n),
    .wr_n_i(wr_n), .rd_n_i(rd_n), .addr_i(addr), .data_i(data),
    .data_o(data_o), .data_oe_n_o(data_oe_n_o), .sub_mode_i(sub_mode),
    .pcm_mode_i(pcm_mode), .frame_sync_i(fs), .bit_clock_i(bclk),
    .pcm_rx_i(pcm_rx), .pcm_tx_o(pcm_tx), .pcm_oe_n_o(pcm_oe_n),
    .sub_rx_i(sub_rx), .sub_tx_o(sub_tx), .sub_oe_n_o(sub_oe_n));

  stt_far_end i_stt_far_end (.clock_i(clock_i), .reset_i(reset_i),
    .pcm_tx_i(pcm_tx), .pcm_oe_n_i(pcm_oe_n), .sub_tx_i(sub_tx),
    .sub_oe_n_i(sub_oe_n), .bit_clock_o(bclk), .frame_sync_o(fs),
    .pcm_rx_o(pcm_rx), .sub_rx_o(sub_rx));

  always #50 clock_i = ~clock_i;

  // ****************************************
  // register port tasks
  // ****************************************
  task automatic wr(input logic [3:0] off, input logic [7:0] val);
    @(negedge clock_i);
    cs_n = 1'b0;
    wr_n = 1'b0;
    addr = off;
    data = val;
    repeat (4) @(negedge clock_i);
    cs_n = 1'b1;
    wr_n = 1'b1;
    repeat (3) @(negedge clock_i);
  endtask

  task automatic chk_rd(input logic [3:0] off, input logic [7:0] exp);
    int n;
    @(negedge clock_i);
    cs_n = 1'b0;
    rd_n = 1'b0;
    addr = off;
    n = 0;
    while (data_oe_n_o !== 1'b0 && n < 10) begin
      @(negedge clock_i);
      n++;
    end
    `CHK(data_oe_n_o, 1'b0)
    `CHK(data_o, exp)
    cs_n = 1'b1;
    rd_n = 1'b1;
    repeat (4) @(negedge clock_i);
  endtask

  // two full frames, so one whole frame follows any register change
  task automatic frames();
    repeat (1400) @(negedge clock_i);
  endtask

  task automatic close_out();
    if (mismatches == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge clock_i);
    mismatches++;
    close_out();
  end

  initial begin
    clock_i = 1'b0;
    reset_i = 1'b1;
    {cs_n, wr_n, rd_n} = 3'h7;
    addr = 4'h0;
    data = 8'h00;
    sub_mode = 2'h2;
    pcm_mode = 2'h2;
    mismatches = 0;
    num_checks = 0;
    repeat (12) @(posedge clock_i);
    @(negedge clock_i);
    reset_i = 1'b0;
    // ****************************************
    // reset values, read-back, unmapped place
    // ****************************************
    for (int i = 1; i < 10; i++) chk_rd(4'(i), 8'h00);
    for (int i = 1; i < 10; i++) wr(4'(i), 8'(i * 8'h13));
    wr(4'hF, 8'hFF);
    for (int i = 1; i < 10; i++) chk_rd(4'(i), 8'(i * 8'h13));
    chk_rd(4'hF, 8'h00);
    // receive: A from highway slot 2, B from subscriber slot 5
    wr(`STT_OFF_TX_A, 8'h64);
    wr(`STT_OFF_TX_B, 8'h64);
    wr(`STT_OFF_RX_A, 8'h02);
    wr(`STT_OFF_RX_B, 8'h85);
    wr(`STT_OFF_CTRL, 8'hC9);
    frames();
    e = i_stt_far_end.rx_byte(1'b0, 3'h2);
    chk_rd(`STT_OFF_DATA_A, e);
    e = i_stt_far_end.rx_byte(1'b1, 3'h5);
    chk_rd(`STT_OFF_DATA_B, e);
    // transmit: receive slots parked beyond the short frame
    wr(`STT_OFF_RX_A, 8'h64);
    wr(`STT_OFF_RX_B, 8'hE4);
    wr(`STT_OFF_DATA_A, 8'hC3);
    wr(`STT_OFF_DATA_B, 8'h96);
    wr(`STT_OFF_TX_A, 8'h83);
    wr(`STT_OFF_TX_B, 8'h06);
    frames();
    `CHK(i_stt_far_end.cap_sub[3], 8'hC3)
    `CHK(i_stt_far_end.cap_pcm[6], 8'h96)
    chk_rd(`STT_OFF_DATA_A, 8'hC3);
    // disabled channel moves nothing
    wr(`STT_OFF_CTRL, 8'h09);
    wr(`STT_OFF_DATA_A, 8'h00);
    wr(`STT_OFF_RX_A, 8'h02);
    frames();
    chk_rd(`STT_OFF_DATA_A, 8'h00);
    // half-slot type: only slot bits 3..0 land in the buffer
    wr(`STT_OFF_CTRL, 8'h42);
    frames();
    e = i_stt_far_end.rx_byte(1'b0, 3'h2) & 8'h0F;
    chk_rd(`STT_OFF_DATA_A, e);
    // subscriber mode 0: valid and invalid address
    sub_mode = 2'h0;
    wr(`STT_OFF_RX_B, 8'h89);
    wr(`STT_OFF_CTRL, 8'h88);
    frames();
    e = i_stt_far_end.rx_byte(1'b1, 3'h3);
    chk_rd(`STT_OFF_DATA_B, e);
    wr(`STT_OFF_DATA_B, 8'h00);
    wr(`STT_OFF_RX_B, 8'h8B);
    frames();
    chk_rd(`STT_OFF_DATA_B, 8'h00);
    // subscriber mode 3: port 0 odd slot gives flat slot 1
    sub_mode = 2'h3;
    wr(`STT_OFF_RX_B, 8'h81);
    frames();
    e = i_stt_far_end.rx_byte(1'b1, 3'h1);
    chk_rd(`STT_OFF_DATA_B, e);
    // subscriber mode 3: port bits 001 are refused
    wr(`STT_OFF_DATA_B, 8'h00);
    wr(`STT_OFF_RX_B, 8'h83);
    frames();
    chk_rd(`STT_OFF_DATA_B, 8'h00);
    // mode 1 on both sides: highway slot 3, subscriber slot 2
    sub_mode = 2'h1;
    pcm_mode = 2'h1;
    wr(`STT_OFF_RX_A, 8'h03);
    wr(`STT_OFF_RX_B, 8'h84);
    wr(`STT_OFF_CTRL, 8'hC9);
    frames();
    e = i_stt_far_end.rx_byte(1'b0, 3'h3);
    chk_rd(`STT_OFF_DATA_A, e);
    e = i_stt_far_end.rx_byte(1'b1, 3'h2);
    chk_rd(`STT_OFF_DATA_B, e);
    close_out();
  end
endmodule
